// ### hw/sbts_bit_timer.sv
`timescale 1ns/100ps
`include "sbts_regs.svh"

// Bit timer: counts the bit period from the last resync edge and
// pulses once per bit at the chosen sample position.
module sbts_bit_timer #(
  parameter int PW = 16                   // Width of the bit period
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          resync,      // Edge that starts a bit
  input  wire logic [PW-1:0] period,      // Clock cycles per bit
  input  wire logic [6:0]    position,    // Sample point in percent
  output logic               sample_tick
);

  logic [PW-1:0]   cnt;                   // Cycles into the current bit
  logic            tick_q;                // Sample point reached last cycle
  wire  [PW+6:0]   product;
  wire  [PW-1:0]   sample_at;
  wire             wrap;

  // Sample point is period * percent / 100, measured from bit start
  assign product   = period * position;
  assign sample_at = PW'(product / (PW+7)'(`SBTS_PERCENT_FULL));
  assign wrap      = cnt >= period - 1'b1;

  // Count the bit; an edge restarts it so timing tracks the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (resync) begin
      cnt <= {{(PW-1){1'b0}}, 1'b1};
    end else if (wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // One pulse per bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= !resync && cnt == sample_at;
    end
  end

  // A pulse that meets a resync edge is stale: it would sample the new
  // bit at its very start and miscount a break or misread a bit
  assign sample_tick = tick_q && !resync;

endmodule : sbts_bit_timer

// ### hw/sbts_deglitch.sv
`timescale 1ns/100ps
`include "sbts_regs.svh"

// Time hysteresis: the output follows the input only after it has
// disagreed for a whole hold time, so short noise spikes never pass.
module sbts_deglitch #(
  parameter int CW = 4                    // Counter width
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,               // Noise rejection on
  input  wire logic din,
  output logic      dout
);

  logic [CW-1:0] cnt;                     // Cycles of disagreement
  wire  [CW-1:0] need;                    // Required disagreement, minus one
  wire           differ;

  // With rejection off a single cycle of disagreement is enough
  assign need   = enable ? CW'(`SBTS_REJECT_CYCLES - 1) : {CW{1'b0}};
  assign differ = din != dout;

  // Flip only once the disagreement has lasted long enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      dout <= 1'b0;
    end else if (differ && cnt >= need) begin
      cnt  <= '0;
      dout <= din;
    end else if (differ) begin
      cnt  <= cnt + 1'b1;
    end else begin
      cnt  <= '0;
    end
  end

endmodule : sbts_deglitch

// ### hw/sbts_pkg.sv
package sbts_pkg;

  // Which protocol the trigger watches
  typedef enum logic [0:0] {
    SBTS_TRIG_CAN = 1'h0,
    SBTS_TRIG_LIN = 1'h1
  } sbts_trig_type;

  // Observed bus view; only the high line is dominant-high
  typedef enum logic [2:0] {
    SBTS_SIG_CANH = 3'h0,
    SBTS_SIG_CANL = 3'h1,
    SBTS_SIG_RX   = 3'h2,
    SBTS_SIG_TX   = 3'h3,
    SBTS_SIG_DIFF = 3'h4
  } sbts_signal_type;

  // Sweep mode of the sequencer
  typedef enum logic [1:0] {
    SBTS_SWEEP_NORMAL = 2'h0,
    SBTS_SWEEP_AUTO   = 2'h1,
    SBTS_SWEEP_SINGLE = 2'h2
  } sbts_sweep_type;

  // Reported status
  typedef enum logic [1:0] {
    SBTS_STAT_SEARCH  = 2'h0,
    SBTS_STAT_TRIGD   = 2'h1,
    SBTS_STAT_STOPPED = 2'h2
  } sbts_status_type;

  // Single-wire bus protocol revision
  typedef enum logic [1:0] {
    SBTS_LIN_REV13 = 2'h0,
    SBTS_LIN_REV20 = 2'h1,
    SBTS_LIN_REV21 = 2'h2
  } sbts_linrev_type;

  // Sequencer states
  typedef enum logic [1:0] {
    SBTS_ST_ARMED = 2'h0,
    SBTS_ST_HOLD  = 2'h1,
    SBTS_ST_STOP  = 2'h2
  } sbts_state_type;

endpackage : sbts_pkg

// ### hw/sbts_regs.svh
`ifndef SBTS_REGS_SVH
`define SBTS_REGS_SVH

// Clock period of the sampling clock, 125 MHz
`define SBTS_CLK_PERIOD_NS      8

// Sample position in percent of the bit period
`define SBTS_POS_DEFAULT        7'h4B
`define SBTS_POS_MAX            7'h63
`define SBTS_PERCENT_FULL       100

// Smallest sync-break length in bit clocks
`define SBTS_LIN_BREAK_FLOOR    5'h0D

// Recessive bits that count as an idle bus before a frame start
`define SBTS_IDLE_BITS          4'hB

// Equal bits after which the transmitter inserts a stuff bit
`define SBTS_STUFF_LIMIT        3'h5

// Bit indices after the frame start (the frame start itself is index 0)
`define SBTS_BASE_FIRST_IDX     6'h01
`define SBTS_BASE_LAST_IDX      6'h0B
`define SBTS_IDE_IDX            6'h0D
`define SBTS_EXT_FIRST_IDX      6'h0E
`define SBTS_EXT_LAST_IDX       6'h1F

// Noise-rejection hold time, least time so the count rounds up
`define SBTS_REJECT_TIME_NS     40
`define SBTS_REJECT_CYCLES      ((`SBTS_REJECT_TIME_NS + `SBTS_CLK_PERIOD_NS - 1) / `SBTS_CLK_PERIOD_NS)

// Auto-mode wait before a forced trigger, longest time so it rounds down
`define SBTS_AUTO_TIMEOUT_US    1000
`define SBTS_AUTO_TIMEOUT_CYCLES ((`SBTS_AUTO_TIMEOUT_US * 1000) / `SBTS_CLK_PERIOD_NS)

`endif

// ### hw/sbts_top.sv
// Notes on behaviour
// RULE_01: CAN mode triggers on frame-start bit, both formats.
// RULE_02: Signal setting picks bus view and polarity.
// RULE_03: Bits timed from configurable bit-rate setting.
// RULE_04: Sample at percent of bit, default 75.
// RULE_05: Standard select: 11-bit or 29-bit identifier decoding.
// RULE_06: LIN mode triggers on sync-break rising exit.
// RULE_07: Minimum break length selectable, at least 13.
// RULE_08: LIN revision setting: 1.3, 2.0 or 2.1.
// RULE_09: Normal mode captures only on met condition.
// RULE_10: Auto mode forces trigger when none found.
// RULE_11: Single mode captures once, stops, rearms on run.
// RULE_12: Status reports triggered, searching or stopped.
// RULE_13: Holdoff after trigger ignores events, then rearms.
// RULE_14: Noise rejection adds hysteresis to detection.
// RULE_15: Frame start accepted only after idle bus.
// RULE_16: Break measured in bit periods before rising edge.
`timescale 1ns/100ps
`include "sbts_regs.svh"

module sbts_top #(
  parameter int PW          = 16,                         // Bit period width
  parameter int AUTO_CYCLES = `SBTS_AUTO_TIMEOUT_CYCLES   // Auto-mode wait
) (
  input  wire logic                     CLK,
  input  wire logic                     RST,
  input  wire logic                     BUS_CANH,
  input  wire logic                     BUS_CANL,
  input  wire logic                     BUS_RX,
  input  wire logic                     BUS_TX,
  input  wire logic                     BUS_DIFF,
  input  wire sbts_pkg::sbts_trig_type   TRIG_TYPE,
  input  wire sbts_pkg::sbts_signal_type SIGNAL_SEL,
  input  wire logic [PW-1:0]            BIT_PERIOD,
  input  wire logic [6:0]               BIT_SAMPLE_POSITION,
  input  wire logic                     CAN_EXTENDED,
  input  wire logic [4:0]               LIN_BREAK_MIN,
  input  wire sbts_pkg::sbts_linrev_type LIN_REVISION,
  input  wire sbts_pkg::sbts_sweep_type  SWEEP_MODE,
  input  wire logic                     RUN_CMD,
  input  wire logic [31:0]              HOLDOFF_CYCLES,
  input  wire logic                     NOISE_REJECT,
  output logic                          CAPTURE_REQ,
  output logic                          CAPTURE_FORCED,
  output sbts_pkg::sbts_status_type     STATUS,
  output logic [28:0]                   FRAME_ID,
  output logic                          FRAME_ID_VALID,
  output logic                          FRAME_EXTENDED,
  output sbts_pkg::sbts_linrev_type     LIN_FRAME_REV
);
  import sbts_pkg::*;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // ---------------- Bus view and polarity ----------------
  wire        sel_view;                   // Chosen digitised view
  wire        dom_raw;                    // One while the bus is dominant
  logic       dom;                        // Filtered dominant level
  logic       dom_q;                      // Dominant level one cycle back
  wire        fall_edge;                  // Recessive to dominant
  wire        rise_edge;                  // Dominant to recessive

  assign sel_view = (SIGNAL_SEL == SBTS_SIG_CANH) ? BUS_CANH :
                    (SIGNAL_SEL == SBTS_SIG_CANL) ? BUS_CANL :
                    (SIGNAL_SEL == SBTS_SIG_RX)   ? BUS_RX   :
                    (SIGNAL_SEL == SBTS_SIG_TX)   ? BUS_TX   : BUS_DIFF;
  // Only the high line is dominant-high; every other view is inverted
  assign dom_raw  = (SIGNAL_SEL == SBTS_SIG_CANH) ? sel_view : !sel_view; // RULE_02

  // Hysteresis in time; costs a few cycles of latency when enabled
  sbts_deglitch #(.CW(4)) u_reject (
    .clk    (CLK),
    .rst    (RST),
    .enable (NOISE_REJECT),               // RULE_14
    .din    (dom_raw),
    .dout   (dom)
  );

  // Edge history of the filtered level
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dom_q <= 1'b0;
    end else begin
      dom_q <= dom;
    end
  end

  assign fall_edge = dom && !dom_q;
  assign rise_edge = !dom && dom_q;

  // ---------------- Bit timing ----------------
  wire [6:0]  pos_eff;                    // Sample position in use
  wire        tick;                       // One pulse per bit at sample point

  // Out-of-range positions fall back to the default
  assign pos_eff = (BIT_SAMPLE_POSITION == 7'h00 || BIT_SAMPLE_POSITION > `SBTS_POS_MAX) ?
                   `SBTS_POS_DEFAULT : BIT_SAMPLE_POSITION;       // RULE_04

  // Every recessive-to-dominant edge resynchronises the bit clock
  sbts_bit_timer #(.PW(PW)) u_timer (
    .clk         (CLK),
    .rst         (RST),
    .resync      (fall_edge),
    .period      (BIT_PERIOD),            // RULE_03
    .position    (pos_eff),
    .sample_tick (tick)
  );

  // ---------------- CAN idle and frame start ----------------
  logic [3:0] idle_cnt;                   // Recessive bits seen in a row
  wire        bus_idle;
  wire        sof_evt;

  assign bus_idle = idle_cnt == `SBTS_IDLE_BITS;

  // Count recessive samples up to the idle threshold
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      idle_cnt <= 4'h0;
    end else if (tick && dom) begin
      idle_cnt <= 4'h0;
    end else if (tick && !bus_idle) begin
      idle_cnt <= idle_cnt + 4'h1;        // RULE_15
    end
  end

  // Dominant bits inside a frame never look like a start
  assign sof_evt = (TRIG_TYPE == SBTS_TRIG_CAN) && fall_edge && bus_idle; // RULE_01 RULE_15

  // ---------------- CAN identifier decoding ----------------
  logic        in_frame;                  // Decoding an arbitration field
  logic [5:0]  bit_idx;                   // Data bits taken since frame start
  logic [2:0]  run_len;                   // Equal bits in a row
  logic        last_bit;
  logic [28:0] id_sh;                     // Identifier, first bit highest
  wire         data_bit;                  // Logic bit value; dominant is zero
  wire         stuff_bit;
  wire         take;
  wire         shift_en;
  wire         at_ide;
  wire         ide_mismatch;
  wire         base_done;
  wire         ext_done;
  wire         frame_end;
  wire [2:0]   next_run;

  assign data_bit  = !dom;
  // A bit after five equal ones is stuffing and carries no data
  assign stuff_bit = run_len == `SBTS_STUFF_LIMIT;
  assign take      = in_frame && tick && !stuff_bit;
  assign shift_en  = take && ((bit_idx >= `SBTS_BASE_FIRST_IDX &&
                               bit_idx <= `SBTS_BASE_LAST_IDX) ||
                              bit_idx >= `SBTS_EXT_FIRST_IDX);
  assign at_ide    = take && bit_idx == `SBTS_IDE_IDX;
  // Format flag has to match the chosen standard
  assign ide_mismatch = at_ide && (data_bit != CAN_EXTENDED);        // RULE_05
  assign base_done = at_ide && !CAN_EXTENDED && !data_bit;
  assign ext_done  = take && CAN_EXTENDED && bit_idx == `SBTS_EXT_LAST_IDX;
  assign frame_end = base_done || ext_done || ide_mismatch;
  assign next_run  = (stuff_bit || data_bit != last_bit) ? 3'h1 : run_len + 3'h1;

  // Frame decode state; the frame-start bit is index zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_frame <= 1'b0;
      bit_idx  <= 6'h00;
      run_len  <= 3'h0;
      last_bit <= 1'b0;
    end else if (sof_evt) begin
      in_frame <= 1'b1;
      bit_idx  <= 6'h00;
      run_len  <= 3'h0;
      last_bit <= 1'b0;
    end else if (in_frame && tick) begin
      in_frame <= !frame_end;
      bit_idx  <= take ? bit_idx + 6'h01 : bit_idx;
      run_len  <= next_run;
      last_bit <= data_bit;
    end
  end

  // Identifier shifter
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      id_sh <= 29'h0;
    end else if (shift_en) begin
      id_sh <= {id_sh[27:0], data_bit};
    end
  end

  // Identifier result, held until the next one
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FRAME_ID       <= 29'h0;
      FRAME_ID_VALID <= 1'b0;
      FRAME_EXTENDED <= 1'b0;
    end else begin
      FRAME_ID_VALID <= base_done || ext_done;
      if (base_done) begin
        FRAME_ID       <= {18'h0, id_sh[10:0]};
        FRAME_EXTENDED <= 1'b0;
      end else if (ext_done) begin
        FRAME_ID       <= {id_sh[27:0], data_bit};
        FRAME_EXTENDED <= 1'b1;
      end
    end
  end

  // ---------------- LIN sync break ----------------
  logic [4:0] dom_cnt;                    // Dominant bit periods in a row
  wire  [4:0] break_min;
  wire        lin_evt;

  // Settings below the floor are raised to it
  assign break_min = (LIN_BREAK_MIN < `SBTS_LIN_BREAK_FLOOR) ?
                     `SBTS_LIN_BREAK_FLOOR : LIN_BREAK_MIN;         // RULE_07
  assign lin_evt   = (TRIG_TYPE == SBTS_TRIG_LIN) && rise_edge &&
                     dom_cnt >= break_min;                         // RULE_06 RULE_16

  // Saturating count of dominant samples; a rising edge ends the run
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dom_cnt <= 5'h00;
    end else if (rise_edge || (tick && !dom)) begin
      dom_cnt <= 5'h00;
    end else if (tick && dom_cnt != 5'h1F) begin
      dom_cnt <= dom_cnt + 5'h01;         // RULE_16
    end
  end

  // ---------------- Sweep sequencer ----------------
  sbts_state_type  st;
  sbts_state_type  next_st;
  sbts_status_type next_status;
  logic [31:0]     hold_cnt;              // Holdoff cycles left
  logic [31:0]     auto_cnt;              // Cycles armed without a trigger
  wire             fire;
  wire             timeout;
  wire             force_trig;
  wire             take_trig;

  assign fire       = sof_evt || lin_evt;
  assign timeout    = auto_cnt == 32'(AUTO_CYCLES - 1);
  // Forced capture keeps auto mode running on a quiet bus
  assign force_trig = st == SBTS_ST_ARMED && !fire && timeout &&
                      SWEEP_MODE == SBTS_SWEEP_AUTO;               // RULE_10
  // Events outside the armed state are dropped
  assign take_trig  = st == SBTS_ST_ARMED && (fire || force_trig); // RULE_09 RULE_13

  // Next state
  always_comb begin
    case (st)
      SBTS_ST_ARMED: next_st = !take_trig ? SBTS_ST_ARMED :
                               (SWEEP_MODE == SBTS_SWEEP_SINGLE) ? SBTS_ST_STOP :
                               SBTS_ST_HOLD;                       // RULE_11
      SBTS_ST_HOLD:  next_st = (hold_cnt == 32'h0) ? SBTS_ST_ARMED : SBTS_ST_HOLD; // RULE_13
      SBTS_ST_STOP:  next_st = RUN_CMD ? SBTS_ST_ARMED : SBTS_ST_STOP;  // RULE_11
      default:       next_st = SBTS_ST_ARMED;
    endcase
  end

  // Next status: a real trigger wins over the quiet-bus timeout
  always_comb begin
    if (take_trig && SWEEP_MODE == SBTS_SWEEP_SINGLE) begin
      next_status = SBTS_STAT_STOPPED;    // RULE_12
    end else if (take_trig && fire) begin
      next_status = SBTS_STAT_TRIGD;
    end else if (st == SBTS_ST_ARMED && timeout) begin
      next_status = SBTS_STAT_SEARCH;
    end else if (st == SBTS_ST_STOP && RUN_CMD) begin
      next_status = SBTS_STAT_SEARCH;
    end else begin
      next_status = STATUS;
    end
  end

  // State and capture outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st             <= SBTS_ST_ARMED;
      STATUS         <= SBTS_STAT_SEARCH;
      CAPTURE_REQ    <= 1'b0;
      CAPTURE_FORCED <= 1'b0;
    end else begin
      st             <= next_st;
      STATUS         <= next_status;
      CAPTURE_REQ    <= take_trig;        // RULE_09
      CAPTURE_FORCED <= force_trig;
    end
  end

  // Holdoff countdown; zero still gives one cycle in hold
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold_cnt <= 32'h0;
    end else if (take_trig) begin
      hold_cnt <= HOLDOFF_CYCLES;         // RULE_13
    end else if (st == SBTS_ST_HOLD && hold_cnt != 32'h0) begin
      hold_cnt <= hold_cnt - 32'h1;
    end
  end

  // Quiet-bus timer, runs only while armed
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      auto_cnt <= 32'h0;
    end else if (st != SBTS_ST_ARMED || take_trig || timeout) begin
      auto_cnt <= 32'h0;
    end else begin
      auto_cnt <= auto_cnt + 32'h1;
    end
  end

  // Revision in force when a sync break fired a capture
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LIN_FRAME_REV <= SBTS_LIN_REV13;
    end else if (take_trig && lin_evt) begin
      LIN_FRAME_REV <= LIN_REVISION;      // RULE_08
    end
  end

  // ---------------- Checks ----------------
  sequence armed_single_fire;
    st == SBTS_ST_ARMED && fire && SWEEP_MODE == SBTS_SWEEP_SINGLE;
  endsequence
  sequence stopped_report;
    st == SBTS_ST_STOP && STATUS == SBTS_STAT_STOPPED && CAPTURE_REQ;
  endsequence

  chk_sof_after_idle: assert property (sof_evt |-> idle_cnt == 4'hB && !dom_q) // RULE_15
    else $error("frame start taken without idle bus");
  chk_capture_armed: assert property (CAPTURE_REQ |-> $past(st) == SBTS_ST_ARMED) // RULE_13
    else $error("capture requested outside armed state");
  chk_single_stop: assert property (armed_single_fire |=> stopped_report) // RULE_11
    else $error("single capture did not stop");
  chk_stop_holds: assert property (st == SBTS_ST_STOP && !RUN_CMD |=> st == SBTS_ST_STOP) // RULE_11
    else $error("stopped state left without run");
  chk_force_auto: assert property (CAPTURE_FORCED |-> CAPTURE_REQ &&
                                   $past(SWEEP_MODE) == SBTS_SWEEP_AUTO) // RULE_10
    else $error("forced capture outside auto mode");
  chk_auto_timeout: assert property (st == SBTS_ST_ARMED && timeout && !fire &&
                                     SWEEP_MODE == SBTS_SWEEP_AUTO |=> CAPTURE_FORCED) // RULE_10
    else $error("auto mode did not force");
  chk_break_length: assert property (lin_evt |-> dom_cnt >= 5'hD) // RULE_07
    else $error("sync break shorter than floor");
  chk_holdoff_gap: assert property (CAPTURE_REQ && st == SBTS_ST_HOLD && hold_cnt != 32'h0
                                    |=> !CAPTURE_REQ [*2]) // RULE_13
    else $error("captures closer than holdoff allows");
  chk_status_trig: assert property (st == SBTS_ST_ARMED && fire &&
                                    SWEEP_MODE != SBTS_SWEEP_SINGLE
                                    |=> STATUS == SBTS_STAT_TRIGD) // RULE_12
    else $error("status not triggered after trigger");

endmodule : sbts_top

// ### test/sbts_bus_model.sv
`timescale 1ns/100ps
// Far-side bus: one bit value shown on every view the block can select
module sbts_bus_model #(
  parameter int PER = 10    // Clock cycles per bus bit
) (
  input  wire logic clk,
  output logic      canh,
  output logic      canl,
  output logic      rx,
  output logic      tx,
  output logic      diff
);
  logic lvl  = 1'b1;        // Bit value, 0 is dominant; idles recessive
  logic last = 1'b1;        // Previous bit, for stuffing
  int   run  = 0;           // Equal bits in a row
  // Only the high line shows dominant as a high level
  assign canh = ~lvl;
  assign canl = lvl;
  assign rx   = lvl;
  assign tx   = lvl;
  assign diff = lvl;
  // Hold a level for n clocks; changes land on the falling edge
  task automatic put(input logic b, input int n);
    @(negedge clk);
    lvl = b;
    repeat (n - 1) @(negedge clk);
  endtask : put
  // Recessive bus for a number of bit times
  task automatic idle(input int bits);
    put(1'b1, bits * PER);
  endtask : idle
  // One bit, then a stuff bit after five equal ones
  task automatic sbit(input logic b);
    put(b, PER);
    run  = (b == last) ? run + 1 : 1;
    last = b;
    if (run == 5) begin
      put(~b, PER);
      last = ~b;
      run  = 1;
    end
  endtask : sbit
  // Data frame without payload, identifier sent MSB first
  task automatic frame(input logic [28:0] id, input logic ext);
    run  = 0;
    last = 1'b1;
    sbit(1'b0);
    for (int i = 10; i >= 0; i--) sbit(ext ? id[i + 18] : id[i]);
    sbit(ext);
    sbit(ext);
    if (ext) for (int i = 17; i >= 0; i--) sbit(id[i]);
    repeat (6) sbit(1'b0);
  endtask : frame
endmodule : sbts_bus_model

// ### test/sbts_top_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end

module sbts_top_tb;
  import sbts_pkg::*;
  localparam int PER = 10;        // Clock cycles per bus bit
  logic clk = 1'b0, rst = 1'b1;   // Clock and reset
  logic canh, canl, rx, tx, diff; // Bus views
  sbts_trig_type   trig = SBTS_TRIG_CAN;
  sbts_signal_type sel  = SBTS_SIG_CANL;
  sbts_sweep_type  sweep = SBTS_SWEEP_NORMAL;
  sbts_linrev_type rev  = SBTS_LIN_REV13;
  logic [31:0] hold = 32'h14;     // Short holdoff, well under a frame gap
  logic ext = 1'b0, run = 1'b0, nr = 1'b0;
  logic [15:0] per = 16'(PER);    // Bit period setting
  logic [6:0]  pos = 7'h4B;       // Sample position setting
  logic [4:0]  brk = 5'h0D;       // Minimum break setting
  logic cap, forced, fval, fext;  // Design outputs
  logic [28:0] fid;
  sbts_status_type stat, stat_cap;
  sbts_linrev_type frev;
  int mismatches = 0, total_checks = 0, caps = 0, forced_n = 0, ids = 0, c0, i0, n;

  always #4 clk = ~clk;
  // Count events; status is taken in the capture cycle itself
  always @(posedge clk) begin
    if (cap === 1'b1) begin
      caps++;
      stat_cap = stat;
    end
    if (forced === 1'b1) forced_n++;
    if (fval === 1'b1) ids++;
  end

  sbts_bus_model #(.PER(PER)) sbts_bus_model_inst (.clk(clk), .canh(canh), .canl(canl),
    .rx(rx), .tx(tx), .diff(diff));

  sbts_top #(.PW(16), .AUTO_CYCLES(50)) sbts_top_inst (
    .CLK(clk), .RST(rst), .BUS_CANH(canh), .BUS_CANL(canl), .BUS_RX(rx), .BUS_TX(tx),
    .BUS_DIFF(diff), .TRIG_TYPE(trig), .SIGNAL_SEL(sel), .BIT_PERIOD(per),
    .BIT_SAMPLE_POSITION(pos), .CAN_EXTENDED(ext), .LIN_BREAK_MIN(brk),
    .LIN_REVISION(rev), .SWEEP_MODE(sweep), .RUN_CMD(run), .HOLDOFF_CYCLES(hold),
    .NOISE_REJECT(nr), .CAPTURE_REQ(cap), .CAPTURE_FORCED(forced), .STATUS(stat),
    .FRAME_ID(fid), .FRAME_ID_VALID(fval), .FRAME_EXTENDED(fext), .LIN_FRAME_REV(frev));

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // One frame, then idle, and the number of captures it caused
  task automatic frame_chk(input logic [28:0] id, input logic e, input int dc);
    c0 = caps;
    sbts_bus_model_inst.frame(id, e);
    sbts_bus_model_inst.idle(12);
    `CHK(caps - c0, dc)
  endtask : frame_chk

  // Rearm pulse, one clock wide
  task automatic rearm();
    @(negedge clk) run = 1'b1;
    @(negedge clk) run = 1'b0;
  endtask : rearm

  // Hang guard: the run is far shorter than this
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    sbts_bus_model_inst.idle(12);
    // Every view with its own polarity; in-frame dominant bits must not retrigger
    for (int s = 0; s < 5; s++) begin
      sel = sbts_signal_type'(s);
      frame_chk(29'h5A3 + s, 1'b0, 1);
      `CHK(fid, 29'h5A3 + s)
      `CHK(fext, 1'b0)
      `CHK(stat_cap, SBTS_STAT_TRIGD)
    end
    ext = 1'b1;
    frame_chk(29'h0ACE1357, 1'b1, 1);
    `CHK(fid, 29'h0ACE1357)
    `CHK(fext, 1'b1)
    // Base frame while extended decode is asked for: no identifier
    `CHK(ids, 6)
    i0 = ids;
    frame_chk(29'h123, 1'b0, 1);
    `CHK(ids - i0, 0)
    ext = 1'b0;
    // Long holdoff swallows the second frame
    hold = 32'h7D0;
    frame_chk(29'h111, 1'b0, 1);
    frame_chk(29'h222, 1'b0, 0);
    hold = 32'h14;
    sbts_bus_model_inst.idle(200);
    c0 = caps;
    sbts_bus_model_inst.idle(20);
    `CHK(caps - c0, 0)
    `CHK(stat, SBTS_STAT_SEARCH)
    sweep = SBTS_SWEEP_AUTO;
    c0 = forced_n;
    sbts_bus_model_inst.idle(10);
    `CHK(forced_n > c0, 1'b1)
    `CHK(stat, SBTS_STAT_SEARCH)
    sweep = SBTS_SWEEP_SINGLE;
    sbts_bus_model_inst.idle(5);
    frame_chk(29'h3C5, 1'b0, 1);
    `CHK(stat, SBTS_STAT_STOPPED)
    frame_chk(29'h3C6, 1'b0, 0);
    rearm();
    frame_chk(29'h3C7, 1'b0, 1);
    sweep = SBTS_SWEEP_NORMAL;
    rearm();
    // A three-clock spike passes only without the hold filter
    c0 = caps;
    sbts_bus_model_inst.put(1'b0, 3);
    sbts_bus_model_inst.idle(12);
    `CHK(caps - c0, 1)
    nr = 1'b1;
    c0 = caps;
    sbts_bus_model_inst.put(1'b0, 3);
    sbts_bus_model_inst.idle(12);
    `CHK(caps - c0, 0)
    frame_chk(29'h0F0, 1'b0, 1);
    nr = 1'b0;
    // One bit short of the minimum is refused, the minimum qualifies; settings
    // below 13 act as 13, an out-of-range sample position acts as 75
    trig = SBTS_TRIG_LIN;
    sel = SBTS_SIG_RX;
    per = 16'h10;
    pos = 7'h64;
    for (int r = 0; r < 3; r++) begin
      rev = sbts_linrev_type'(r);
      brk = (r == 2) ? 5'h0F : (r == 1) ? 5'h05 : 5'h0D;
      n = (r == 2) ? 15 : 13;
      c0 = caps;
      sbts_bus_model_inst.put(1'b0, (n - 1) * 16);
      sbts_bus_model_inst.idle(3);
      `CHK(caps - c0, 0)
      sbts_bus_model_inst.put(1'b0, n * 16);
      sbts_bus_model_inst.idle(3);
      `CHK(caps - c0, 1)
      `CHK(frev, sbts_linrev_type'(r))
    end
    summarize();
  end
endmodule : sbts_top_tb
